// >>> hdl/ext_irq_priority_controller.sv
// interrupt priority registers, pin request detection and request selection
//
// Summary of operation
// - five 16-bit read/write priority registers
// - four 4-bit level fields per register
// - field value is unsigned level 0..15
// - all level fields reset to zero
// - maskable source at level zero never forwarded
// - five source classes handled
// - non-maskable is level 16, always accepted
// - non-maskable pin edge, polarity selectable
// - non-maskable acceptance loads mask 15
// - two-bit sense mode per request pin
// - pin levels from first two registers
// - low mode: request while pin low
// - status flags show pending pin requests
// - edge modes record selected transition only
// - edge request latched until accepted
// - software clears flag only by read-1-then-write-0
// - pin acceptance loads pin's level
// - forward only above current mask level
// - equal levels: smaller vector number wins
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "irq_prio_defs.svh"

module ext_irq_priority_controller
    import irq_prio_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    // register bus
    input  wire axi_req_t               axi_in,
    output axi_rsp_t                    axi_out,
    // request pins
    input  wire logic                   nmi_pin,
    input  wire logic [`NUM_EXT-1:0]    ext_req_pin,
    // other sources
    input  wire logic                   break_req,
    input  wire logic                   debug_req,
    input  wire logic [`NUM_PERIPH-1:0] periph_req,
    // processor side
    input  wire logic [3:0]             cpu_mask_level,
    input  wire logic                   cpu_ack,
    output logic                        irq_req,
    output logic [4:0]                  irq_source,
    output logic [4:0]                  irq_level,
    output logic [3:0]                  irq_mask_load
);

    // ***************************************************************
    // functions
    // ***************************************************************
    function automatic logic [3:0] reg_sel(input logic [7:0] a);
        case ({a[7:2], 2'b00})
            `OFS_PRIO_A:     reg_sel = 4'h0;
            `OFS_PRIO_B:     reg_sel = 4'h1;
            `OFS_PRIO_C:     reg_sel = 4'h2;
            `OFS_PRIO_D:     reg_sel = 4'h3;
            `OFS_PRIO_E:     reg_sel = 4'h4;
            `OFS_CTRL_ZERO:  reg_sel = `SEL_CTRL_ZERO;
            `OFS_EXT_CTRL:   reg_sel = `SEL_EXT_CTRL;
            `OFS_EXT_STATUS: reg_sel = `SEL_EXT_STATUS;
            // unmapped offsets answer with an error response
            default:         reg_sel = `SEL_NONE;
        endcase
    endfunction

    // field k counts from bits 15..12 of the first register
    function automatic logic [3:0] prio_field(input logic [4:0][15:0] p,
                                              input int                k);
        prio_field = p[k/4][(3-(k%4))*`FIELD_W +: `FIELD_W];
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ***************************************************************
    // state
    // ***************************************************************
    state_t                 st_reg;
    state_t                 st_next;
    logic [`NUM_SRC-1:0]    req;
    logic [4:0]             lvl [`NUM_SRC];
    logic [8:0]             pin_fall;
    logic [8:0]             pin_rise;
    logic [7:0]             clr_req;
    logic [3:0]             wsel;
    logic [3:0]             rsel;
    logic                   wr_fire;
    logic                   ack;
    logic                   det;
    logic [1:0]             mode;
    logic [4:0]             best_lvl;
    logic [4:0]             best;

    assign axi_out       = st_reg.bus;
    assign irq_req       = st_reg.irq_req;
    assign irq_source    = st_reg.irq_src;
    assign irq_level     = st_reg.irq_lvl;
    assign irq_mask_load = st_reg.mask_load;

    always_comb begin
        st_next = st_reg;
        det     = 1'b0;
        mode    = 2'b00;
        clr_req = 8'h00;

        // pins held inverted so that reset value zero means idle high
        st_next.s1 = ~{nmi_pin, ext_req_pin};
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        pin_fall   = st_reg.s2 & ~st_reg.s3;
        pin_rise   = ~st_reg.s2 & st_reg.s3;
        ack        = cpu_ack && st_reg.irq_req;

        // ***********************************************************
        // register bus, write side
        // ***********************************************************
        if (axi_in.awvalid && st_reg.bus.awready) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = axi_in.awaddr;
        end
        if (axi_in.wvalid && st_reg.bus.wready) begin
            st_next.w_got = 1'b1;
            st_next.wdata = axi_in.wdata;
            st_next.wstrb = axi_in.wstrb;
        end
        // one cycle to hold both halves, one more to answer
        wr_fire = st_reg.aw_got && st_reg.w_got && !st_reg.bus.bvalid;
        wsel    = reg_sel(st_reg.awaddr);
        if (wr_fire) begin
            st_next.aw_got    = 1'b0;
            st_next.w_got     = 1'b0;
            st_next.bus.bvalid = 1'b1;
            st_next.bus.bresp  = `RESP_OKAY;
            case (wsel)
                4'h0, 4'h1, 4'h2, 4'h3, 4'h4: begin
                    st_next.prio[wsel[2:0]] = merge16(st_reg.prio[wsel[2:0]],
                        st_reg.wdata, st_reg.wstrb);
                end
                `SEL_CTRL_ZERO: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.nmi_edge = st_reg.wdata[`NMI_EDGE_BIT];
                    end
                end
                `SEL_EXT_CTRL: begin
                    st_next.sense = merge16(st_reg.sense, st_reg.wdata,
                        st_reg.wstrb);
                end
                `SEL_EXT_STATUS: begin
                    if (st_reg.wstrb[0]) begin
                        clr_req = ~st_reg.wdata[7:0] & st_reg.armed;
                    end
                    // any status write disarms, so a stale read cannot clear later
                    st_next.armed = 8'h00;
                end
                default: begin
                    st_next.bus.bresp = `RESP_SLVERR;
                end
            endcase
        end
        if (st_reg.bus.bvalid && axi_in.bready) begin
            st_next.bus.bvalid = 1'b0;
        end
        st_next.bus.awready = !st_next.aw_got && !st_next.bus.bvalid;
        st_next.bus.wready  = !st_next.w_got && !st_next.bus.bvalid;

        // ***********************************************************
        // register bus, read side
        // ***********************************************************
        rsel = reg_sel(axi_in.araddr);
        if (axi_in.arvalid && st_reg.bus.arready) begin
            st_next.bus.rvalid = 1'b1;
            st_next.bus.rresp  = `RESP_OKAY;
            // unused upper bits read as zero
            st_next.bus.rdata  = 32'h0000_0000;
            case (rsel)
                4'h0, 4'h1, 4'h2, 4'h3, 4'h4: begin
                    st_next.bus.rdata[15:0] = st_reg.prio[rsel[2:0]];
                end
                `SEL_CTRL_ZERO: begin
                    st_next.bus.rdata[`NMI_EDGE_BIT] = st_reg.nmi_edge;
                end
                `SEL_EXT_CTRL: begin
                    st_next.bus.rdata[15:0] = st_reg.sense;
                end
                `SEL_EXT_STATUS: begin
                    st_next.bus.rdata[7:0] = st_reg.flags;
                    // only bits seen as one may later be cleared
                    st_next.armed = st_next.armed | st_reg.flags;
                end
                default: begin
                    st_next.bus.rresp = `RESP_SLVERR;
                end
            endcase
        end
        if (st_reg.bus.rvalid && axi_in.rready) begin
            st_next.bus.rvalid = 1'b0;
        end
        st_next.bus.arready = !st_next.bus.rvalid;

        // ***********************************************************
        // pin detection
        // ***********************************************************
        for (int i = 0; i < `NUM_EXT; i++) begin
            mode = st_reg.sense[2*i +: 2];
            det  = (mode == SENSE_FALL && pin_fall[i])
                || (mode == SENSE_RISE && pin_rise[i])
                || (mode == SENSE_BOTH && (pin_fall[i] || pin_rise[i]));
            if (mode == SENSE_LOW) begin
                st_next.flags[i] = st_reg.s2[i];
            end else begin
                // a new edge wins over a clear in the same cycle
                st_next.flags[i] = det || (st_reg.flags[i] && !clr_req[i]
                    && !(ack && st_reg.irq_src == `SRC_EXT0 + 5'(i)));
            end
        end
        // non-maskable has no flag; only acceptance clears its latch
        det = st_reg.nmi_edge ? pin_rise[8] : pin_fall[8];
        st_next.nmi_lat = det || (st_reg.nmi_lat
            && !(ack && st_reg.irq_src == `SRC_NMI));
        // break and debug are events, held until accepted
        st_next.brk_lat = break_req || (st_reg.brk_lat
            && !(ack && st_reg.irq_src == `SRC_BREAK));
        st_next.dbg_lat = debug_req || (st_reg.dbg_lat
            && !(ack && st_reg.irq_src == `SRC_DEBUG));

        // ***********************************************************
        // selection, in default order of vector number
        // ***********************************************************
        req[0] = st_reg.brk_lat;
        lvl[0] = `LVL_FIXED;
        req[1] = st_reg.nmi_lat;
        lvl[1] = `LVL_NMI;
        req[2] = st_reg.dbg_lat;
        lvl[2] = `LVL_FIXED;
        for (int i = 0; i < `NUM_EXT; i++) begin
            req[3+i] = st_reg.flags[i];
            lvl[3+i] = {1'b0, prio_field(st_reg.prio, i)};
        end
        // peripheral lines are levels owned by their modules, not latched
        for (int k = 0; k < `NUM_PERIPH; k++) begin
            req[11+k] = periph_req[k];
            lvl[11+k] = {1'b0, prio_field(st_reg.prio, `NUM_EXT + k)};
        end
        // start at zero so a level-zero source can never be chosen
        best_lvl = 5'h00;
        best     = 5'h00;
        for (int i = 0; i < `NUM_SRC; i++) begin
            // strict compare: level zero never wins, ties keep the earlier
            if (req[i] && lvl[i] > best_lvl) begin
                best_lvl = lvl[i];
                best     = 5'(i);
            end
        end
        // the cycle of acceptance drops the request to avoid a repeat
        st_next.irq_req   = (best_lvl > {1'b0, cpu_mask_level}) && !ack;
        st_next.irq_src   = best;
        st_next.irq_lvl   = best_lvl;
        st_next.mask_load = (best == `SRC_NMI) ? `MASK_LOAD_NMI
                                               : best_lvl[3:0];
    end

    // one register holds all state, so reset is a single constant
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    a_zero_masked: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq_req && irq_source >= `SRC_EXT0 |-> irq_level != 5'h00)
        else $error("level zero source forwarded");

    a_mask_compare: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq_req |-> irq_level > {1'b0, $past(cpu_mask_level)})
        else $error("request not above mask level");

    a_nmi_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq_req && irq_source == `SRC_NMI |-> irq_mask_load == 4'hF
            && irq_level == 5'h10)
        else $error("non-maskable load or level wrong");

    a_nmi_always: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_reg.nmi_lat && !ack ##1 !cpu_ack |=> irq_req)
        else $error("non-maskable not forwarded");

    a_nmi_edge: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_reg.nmi_edge && pin_rise[8] |=> st_reg.nmi_lat)
        else $error("selected edge not latched");

    a_level_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_reg.sense[1:0] == SENSE_LOW |=> st_reg.flags[0] == $past(st_reg.s2[0]))
        else $error("low mode flag does not follow pin");

    a_edge_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_reg.sense[1:0] != SENSE_LOW && st_reg.flags[0] && !clr_req[0] && !ack
            |=> st_reg.flags[0])
        else $error("edge request lost");

    a_clear_order: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(st_reg.flags[0]) && $past(st_reg.sense[1:0]) != SENSE_LOW
            && !$past(ack) |-> $past(st_reg.armed[0]))
        else $error("flag cleared without prior read");

    a_ext_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq_req && irq_source == `SRC_EXT0 |-> irq_mask_load == irq_level[3:0])
        else $error("pin mask load wrong");

    a_write_resp: assert property (@(posedge clk_sys) disable iff (!resetn)
        wr_fire |=> axi_out.bvalid)
        else $error("write not answered");

    // ***************************************************************
    // bus and pin path checks
    // ***************************************************************
    // pin 0 stands for all eight; the detection is one loop
    a_write_okay: assert property (@(posedge clk_sys) disable iff (!resetn)
        wr_fire && wsel <= 4'h4 |=> axi_out.bresp == `RESP_OKAY)
        else $error("mapped write refused");

    a_read_answer: assert property (@(posedge clk_sys) disable iff (!resetn)
        axi_in.arvalid && axi_out.arready |=> axi_out.rvalid)
        else $error("read not answered");

    a_status_read: assert property (@(posedge clk_sys) disable iff (!resetn)
        axi_in.arvalid && axi_out.arready && rsel == `SEL_EXT_STATUS
            |=> axi_out.rdata[7:0] == $past(st_reg.flags))
        else $error("status read wrong");

    a_fall_latch: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_reg.sense[1:0] == SENSE_FALL && pin_fall[0] |=> st_reg.flags[0])
        else $error("falling edge not recorded");

    a_rise_ignored: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_reg.sense[1:0] == SENSE_FALL && pin_rise[0] && !st_reg.flags[0]
            |=> !st_reg.flags[0])
        else $error("wrong edge recorded");

    a_sync_chain: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_reg.s2 == $past(st_reg.s1))
        else $error("pin synchroniser skipped a stage");

    a_tie_order: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq_req && irq_source == `SRC_EXT0 + 5'h01
            |-> !($past(st_reg.flags[0]) && $past(prio_field(st_reg.prio, 0))
                == $past(prio_field(st_reg.prio, 1))))
        else $error("tie not won by lower source");

    a_zero_pin: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq_req && irq_source == `SRC_EXT0 |-> $past(prio_field(st_reg.prio, 0)) != 4'h0)
        else $error("pin at level zero forwarded");

endmodule

// >>> pkg/irq_prio_defs.svh
// offsets, field positions, reset values and fixed levels of the priority controller
`ifndef IRQ_PRIO_DEFS_SVH
`define IRQ_PRIO_DEFS_SVH

`define OFS_PRIO_A      8'h00
`define OFS_PRIO_B      8'h04
`define OFS_PRIO_C      8'h08
`define OFS_PRIO_D      8'h0C
`define OFS_PRIO_E      8'h10
`define OFS_CTRL_ZERO   8'h14
`define OFS_EXT_CTRL    8'h18
`define OFS_EXT_STATUS  8'h1C

`define SEL_CTRL_ZERO   4'h5
`define SEL_EXT_CTRL    4'h6
`define SEL_EXT_STATUS  4'h7
`define SEL_NONE        4'hF

`define NMI_EDGE_BIT    0
`define PRIO_RST        16'h0000
`define FIELD_W         4
`define NUM_PRIO_REGS   5
`define NUM_EXT         8
`define NUM_PERIPH      12
`define NUM_SRC         23

`define SRC_BREAK       5'h00
`define SRC_NMI         5'h01
`define SRC_DEBUG       5'h02
`define SRC_EXT0        5'h03
`define SRC_PERIPH0     5'h0B

`define LVL_NMI         5'h10
`define LVL_FIXED       5'h0F
`define MASK_LOAD_NMI   4'hF

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// >>> pkg/irq_prio_pkg.sv
// types of the priority controller: sense modes, bus carriers and the state record
package irq_prio_pkg;

    typedef enum logic [1:0] {
        SENSE_LOW  = 2'b00,
        SENSE_FALL = 2'b01,
        SENSE_RISE = 2'b10,
        SENSE_BOTH = 2'b11
    } sense_mode_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_t;

    typedef struct packed {
        logic [4:0][15:0] prio;
        logic             nmi_edge;
        logic [15:0]      sense;
        logic [7:0]       flags;
        logic [7:0]       armed;
        logic             nmi_lat;
        logic             brk_lat;
        logic             dbg_lat;
        logic [8:0]       s1;
        logic [8:0]       s2;
        logic [8:0]       s3;
        logic             aw_got;
        logic             w_got;
        logic [7:0]       awaddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        axi_rsp_t         bus;
        logic             irq_req;
        logic [4:0]       irq_src;
        logic [4:0]       irq_lvl;
        logic [3:0]       mask_load;
    } state_t;

endpackage

// >>> verification/cpu_core_model.sv
// processor core model: accepts forwarded requests after a chosen delay
`timescale 1ns/100ps

module cpu_core_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // bench controls
    input  wire logic       ack_en,
    input  wire logic [3:0] ack_delay,
    // request side
    input  wire logic       irq_req,
    input  wire logic [4:0] irq_source,
    output logic            cpu_ack,
    output logic [4:0]      acc_src,
    output int              acc_cnt
);
    logic [3:0] wait_cnt;

    // ************
    // acceptance
    // ************
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cpu_ack  <= 1'b0;
            wait_cnt <= 4'h0;
            acc_src  <= 5'h00;
            acc_cnt  <= 0;
        end else begin
            cpu_ack <= 1'b0;
            // one pulse per request; the source is taken at the accepting edge
            if (cpu_ack) begin
                wait_cnt <= 4'h0;
                if (irq_req === 1'b1) begin
                    acc_src <= irq_source;
                    acc_cnt <= acc_cnt + 1;
                end
            end else if (irq_req === 1'b1 && ack_en) begin
                if (wait_cnt >= ack_delay) begin
                    cpu_ack <= 1'b1;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end else begin
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule

// >>> verification/ext_irq_priority_controller_tb.sv
// self-checking bench of the priority controller with a processor model
`timescale 1ns/100ps
`include "irq_prio_defs.svh"

module ext_irq_priority_controller_tb
    import irq_prio_pkg::*;
;
    logic        clk_sys   = 1'b0;
    logic        resetn    = 1'b0;
    axi_req_t    req       = '0;
    axi_rsp_t    rsp;
    logic        nmi_pin   = 1'b1;
    logic [7:0]  ext_pin   = 8'hFF;
    logic [3:0]  mask      = 4'h0;
    logic        ack_en    = 1'b0;
    logic        brk       = 1'b0;
    logic        cpu_ack;
    logic        irq_req;
    logic [4:0]  irq_source;
    logic [4:0]  irq_level;
    logic [4:0]  acc_src;
    logic [3:0]  irq_mask_load;
    logic [3:0]  lvl;
    logic [31:0] rd;
    logic [1:0]  rr;
    logic [15:0] sense_v   = 16'h0000;
    int          acc_cnt;
    int          c0;
    int          k;
    int          error_cnt = 0;
    int          cmp_count = 0;

    always #25 clk_sys = ~clk_sys;

    ext_irq_priority_controller u_ext_irq_priority_controller (
        .clk_sys(clk_sys), .resetn(resetn), .axi_in(req), .axi_out(rsp),
        .nmi_pin(nmi_pin), .ext_req_pin(ext_pin), .break_req(brk), .debug_req(1'b0),
        .periph_req(12'h000), .cpu_mask_level(mask), .cpu_ack(cpu_ack),
        .irq_req(irq_req), .irq_source(irq_source), .irq_level(irq_level),
        .irq_mask_load(irq_mask_load));

    cpu_core_model u_cpu_core_model (
        .clk_sys(clk_sys), .resetn(resetn), .ack_en(ack_en), .ack_delay(4'h2),
        .irq_req(irq_req), .irq_source(irq_source), .cpu_ack(cpu_ack),
        .acc_src(acc_src), .acc_cnt(acc_cnt));

    // ************
    // helpers
    // ************
    function automatic logic edge_hit(input logic [1:0] m, input logic fall);
        return (m == SENSE_BOTH) || (fall ? (m == SENSE_FALL) : (m == SENSE_RISE));
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic timeout(input string what);
        error_cnt++;
        $display("CHECK FAILED %s expected answer seen timeout", what);
        conclude();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // bus writes use all lanes; the 16-bit registers ignore the upper half
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        // an edge passes so bready is not raised where it was lowered
        @(posedge clk_sys);
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_sys);
            rr = rsp.bresp;
            if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) break;
        end
        req.bready <= 1'b0;
        if (k == 40) timeout("write");
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_sys);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_sys);
            rd = rsp.rdata;
            rr = rsp.rresp;
            if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) break;
        end
        req.rready <= 1'b0;
        if (k == 40) timeout("read");
    endtask

    task automatic wait_req(input logic v);
        for (k = 0; k < 40 && irq_req !== v; k++) @(posedge clk_sys);
        if (k == 40) timeout("irq_req");
    endtask

    task automatic set_sense(input int p, input logic [1:0] m);
        sense_v[2*p +: 2] = m;
        wr(`OFS_EXT_CTRL, {16'h0000, sense_v});
    endtask

    // ************
    // tests
    // ************
    initial begin
        rd = $urandom(32'hC5EA9CE4);
        cyc(16);
        resetn <= 1'b1;
        cyc(2);
        for (int i = 0; i < 5; i++) begin
            rd_reg(8'(4 * i));
            check("priority reset", rd, 32'h0);
        end
        rd_reg(`OFS_EXT_STATUS);
        check("status reset", rd, 32'h0);
        rd_reg(8'h20);
        check("unmapped resp", rr, `RESP_SLVERR);
        wr(8'h20, 32'h1);
        check("unmapped write", rr, `RESP_SLVERR);
        $display("test reset done");

        for (int i = 0; i < 5; i++) begin
            c0 = (i == 0) ? 32'hFFFFFFFF : $urandom;
            wr(8'(4 * i), c0);
            check("write resp", rr, `RESP_OKAY);
            rd_reg(8'(4 * i));
            check("priority readback", rd, {16'h0000, c0[15:0]});
            wr(8'(4 * i), 32'h0);
        end
        $display("test registers done");

        lvl = 4'($urandom_range(15, 1));
        wr(`OFS_PRIO_A, {16'h0000, lvl, 12'h000});
        set_sense(0, SENSE_FALL);
        mask <= lvl;
        ext_pin[0] <= 1'b0;
        cyc(2);
        ext_pin[0] <= 1'b1;
        cyc(8);
        check("equal to mask", irq_req, 1'b0);
        mask <= lvl - 4'h1;
        wait_req(1'b1);
        check("pin source", irq_source, `SRC_EXT0);
        check("pin level", irq_level, {1'b0, lvl});
        check("pin mask load", irq_mask_load, lvl);
        ack_en <= 1'b1;
        wait_req(1'b0);
        rd_reg(`OFS_EXT_STATUS);
        check("flag after accept", rd[0], 1'b0);
        ack_en <= 1'b0;
        mask <= 4'h0;
        $display("test pin request done");

        for (int m = 1; m < 4; m++) begin
            set_sense(2, 2'(m));
            for (int f = 0; f < 2; f++) begin
                ext_pin[2] <= f[0];
                cyc(6);
                rd_reg(`OFS_EXT_STATUS);
                check("edge flag", rd[2], edge_hit(2'(m), f == 0));
                check("level zero held", irq_req, 1'b0);
                wr(`OFS_EXT_STATUS, 32'h0);
            end
        end
        $display("test sense modes done");

        set_sense(3, SENSE_FALL);
        ext_pin[3] <= 1'b0;
        cyc(6);
        wr(`OFS_EXT_STATUS, 32'h0);
        rd_reg(`OFS_EXT_STATUS);
        check("write without read", rd[3], 1'b1);
        wr(`OFS_EXT_STATUS, 32'h0);
        rd_reg(`OFS_EXT_STATUS);
        check("read then write", rd[3], 1'b0);
        ext_pin[3] <= 1'b1;
        ext_pin[4] <= 1'b0;
        cyc(6);
        rd_reg(`OFS_EXT_STATUS);
        check("low mode set", rd[4], 1'b1);
        ext_pin[4] <= 1'b1;
        cyc(6);
        rd_reg(`OFS_EXT_STATUS);
        check("low mode gone", rd[4], 1'b0);
        $display("test flag clearing done");

        wr(`OFS_PRIO_A, 32'h00007700);
        set_sense(1, SENSE_FALL);
        ext_pin[1:0] <= 2'b00;
        wait_req(1'b1);
        check("tie winner", irq_source, `SRC_EXT0);
        c0 = acc_cnt;
        ack_en <= 1'b1;
        for (k = 0; k < 60 && acc_cnt < c0 + 2; k++) @(posedge clk_sys);
        if (k == 60) timeout("second accept");
        check("tie second", acc_src, `SRC_EXT0 + 5'h01);
        ack_en <= 1'b0;
        ext_pin[1:0] <= 2'b11;
        $display("test tie done");

        mask <= 4'hF;
        nmi_pin <= 1'b0;
        wait_req(1'b1);
        check("nmi source", irq_source, `SRC_NMI);
        check("nmi level", irq_level, `LVL_NMI);
        check("nmi mask load", irq_mask_load, `MASK_LOAD_NMI);
        ack_en <= 1'b1;
        wait_req(1'b0);
        wr(`OFS_CTRL_ZERO, 32'h1);
        nmi_pin <= 1'b1;
        wait_req(1'b1);
        check("nmi rising", irq_source, `SRC_NMI);
        wait_req(1'b0);
        nmi_pin <= 1'b0;
        cyc(8);
        check("nmi falling ignored", irq_req, 1'b0);
        $display("test nmi done");

        ack_en <= 1'b0;
        mask   <= 4'h0;
        brk    <= 1'b1;
        cyc(1);
        brk    <= 1'b0;
        wait_req(1'b1);
        check("break source", irq_source, `SRC_BREAK);
        check("break mask load", irq_mask_load, 4'hF);
        $display("test break done");
        conclude();
    end
endmodule
